//--- design/day_watch_defines.vh
`ifndef DAY_WATCH_DEFINES_VH
`define DAY_WATCH_DEFINES_VH

// register byte addresses on the serial bus
`define ADDR_ALARM_HOURS   8'h02
`define ADDR_ALARM_MINUTES 8'h03
`define ADDR_ALARM_SECONDS 8'h04
`define ADDR_WATCH_HOURS   8'h05
`define ADDR_WATCH_MINUTES 8'h06
`define ADDR_WATCH_SECONDS 8'h07
`define ADDR_IMPEDANCE     8'h08

// reset values
`define RST_ALARM_HOURS    5'h1f
`define RST_ALARM_MINSEC   6'h3f
`define RST_WATCH_HOURS    5'h00
`define RST_WATCH_MINSEC   6'h00
`define RST_IMPEDANCE      3'h0

// field limits
`define HOURS_MAX          5'h17
`define MINSEC_MAX         6'h3b

// impedance config fields
`define IMP_ENABLE_BIT     2
`define IMP_DELAY_MSB      1

// impedance delays, as printed
`define IMP_DELAY_SEL0_MS  100
`define IMP_DELAY_SEL1_MS  250
`define IMP_DELAY_SEL2_MS  500
`define IMP_DELAY_SEL3_S   1

// timing base
`define SYS_CLK_KHZ        125000
`define TIME_BASE_MS       1
`define OSC_EDGES_PER_SEC  32768

// serial device select, value arbitrary
`define DEV_SELECT_ADDR    7'h30

`endif

//--- design/serial_byte_link.v
`timescale 1ns/1ps
`default_nettype none

module serial_byte_link (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       sclIn,
  input  wire       sdaIn,
  input  wire       ackReq,
  output reg  [7:0] rxByte,
  output reg        rxValid,
  output reg        startSeen,
  output reg        stopSeen,
  output reg        sdaOe
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_BITS = 2'h1;
  localparam [1:0] ST_ACK  = 2'h2;

  reg [2:0] sclSync;
  reg [2:0] sdaSync;
  reg       sclLvl;
  reg       sdaLvl;
  reg       sclPrev;
  reg       sdaPrev;
  reg [1:0] state_r;
  reg [2:0] bitCnt_r;
  reg       ackOn_r;

  wire sclRise   = sclLvl & ~sclPrev;
  wire sclFall   = ~sclLvl & sclPrev;
  wire startCond = sclLvl & sclPrev & sdaPrev & ~sdaLvl;
  wire stopCond  = sclLvl & sclPrev & ~sdaPrev & sdaLvl;

  // three-stage sync; level moves only when stages two and three agree
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclLvl  <= 1'b1;
      sdaLvl  <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
      if (sclSync[1] == sclSync[2]) sclLvl <= sclSync[2];
      if (sdaSync[1] == sdaSync[2]) sdaLvl <= sdaSync[2];
      sclPrev <= sclLvl;
      sdaPrev <= sdaLvl;
    end
  end

  // byte shifter and ack slot; start and stop override any state
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 3'h0;
      ackOn_r   <= 1'b0;
      rxByte    <= 8'h00;
      rxValid   <= 1'b0;
      startSeen <= 1'b0;
      stopSeen  <= 1'b0;
      sdaOe     <= 1'b0;
    end else begin
      rxValid   <= 1'b0;
      startSeen <= 1'b0;
      stopSeen  <= 1'b0;
      if (startCond) begin
        state_r   <= ST_BITS;
        bitCnt_r  <= 3'h0;
        sdaOe     <= 1'b0;
        startSeen <= 1'b1;
      end else if (stopCond) begin
        state_r  <= ST_IDLE;
        sdaOe    <= 1'b0;
        stopSeen <= 1'b1;
      end else begin
        case (state_r)
          ST_BITS: begin
            if (sclRise) begin
              rxByte   <= {rxByte[6:0], sdaLvl};
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7) begin
                rxValid <= 1'b1;
                ackOn_r <= 1'b0;
                state_r <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // ackReq settles one cycle after rxValid, long before scl falls
            if (sclFall) begin
              if (!ackOn_r) begin
                sdaOe   <= ackReq;
                ackOn_r <= 1'b1;
              end else begin
                sdaOe    <= 1'b0;
                bitCnt_r <= 3'h0;
                state_r  <= ST_BITS;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- design/day_watch_alarm.v
// How it works
// - alarm h/m/s at bytes 2,3,4; watch h/m/s at 5,6,7; 5/6-bit fields
// - reset: alarm 31:63:63, watch 00:00:00, so alarm starts disabled
// - alarm time beyond 24:00:00 is disabled and never matches
// - alarm inactive if hours over 23, minutes or seconds over 59
// - alarm hours store low five bits unchanged, even above 23
// - alarm minutes and seconds keep low six bits, wrapping modulo 64
// - watch hours write: low five bits above 23 are clamped to 23
// - watch minutes/seconds keep low six bits; counting runs 0 to 59
// - impedance bit 2 enables half-supply detection
// - disabled detection never shows; enabled detection sets status
// - impedance bits 1:0 pick delay 100ms, 250ms, 500ms or 1s
// - each data byte acked, byte address increments after each byte
// - undecodable address gets no ack; later data ignored
`timescale 1ns/1ps
`include "day_watch_defines.vh"
`default_nettype none

module day_watch_alarm #(
  parameter CLK_KHZ     = `SYS_CLK_KHZ,
  parameter OSC_PER_SEC = `OSC_EDGES_PER_SEC
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output wire       sdaOe,
  input  wire       oscIn,
  input  wire       impedanceIn,
  output reg  [4:0] watchHours,
  output reg  [5:0] watchMinutes,
  output reg  [5:0] watchSeconds,
  output reg        alarmEvent,
  output reg        impedanceDetected
);

  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_SEL  = 3'h1;
  localparam [2:0] PH_ADDR = 3'h2;
  localparam [2:0] PH_DATA = 3'h3;
  localparam [2:0] PH_SKIP = 3'h4;

  // full-width products first, then cut on purpose to the counter widths
  localparam [31:0] MS_CYCLES = CLK_KHZ * `TIME_BASE_MS;
  localparam [31:0] OSC_EDGES = OSC_PER_SEC;
  localparam [16:0] MS_LAST   = MS_CYCLES[16:0] - 17'h00001;
  localparam [15:0] OSC_LAST  = OSC_EDGES[15:0] - 16'h0001;
  localparam [9:0] DLY0 = `IMP_DELAY_SEL0_MS;
  localparam [9:0] DLY1 = `IMP_DELAY_SEL1_MS;
  localparam [9:0] DLY2 = `IMP_DELAY_SEL2_MS;
  localparam [31:0] DLY3_FULL = `IMP_DELAY_SEL3_S * 1000;
  localparam [9:0]  DLY3      = DLY3_FULL[9:0];

  wire [7:0] rxByte;
  wire       rxValid;
  wire       startSeen;
  wire       stopSeen;

  reg [2:0] phase_r;
  reg [7:0] ptr_r;
  reg       ackReq_r;
  reg [4:0] alarmHours_r;
  reg [5:0] alarmMinutes_r;
  reg [5:0] alarmSeconds_r;
  reg [2:0] impConfig_r;
  reg [2:0] oscSync;
  reg       oscLvl;
  reg       oscPrev;
  reg [15:0] oscCnt_r;
  reg       secTick_r;
  reg       tickPend_r;
  reg       advanced_r;
  reg [2:0] impSync;
  reg       impLvl;
  reg [16:0] msCnt_r;
  reg       msTick_r;
  reg [9:0] impCnt_r;
  reg [9:0] delayMs;

  serial_byte_link u_link (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .ackReq    (ackReq_r),
    .rxByte    (rxByte),
    .rxValid   (rxValid),
    .startSeen (startSeen),
    .stopSeen  (stopSeen),
    .sdaOe     (sdaOe)
  );

  // decodable byte addresses
  wire addrOk = (rxByte >= `ADDR_ALARM_HOURS &&
                 rxByte <= `ADDR_WATCH_SECONDS) ||
                rxByte == `ADDR_IMPEDANCE;
  wire wrEn = rxValid && phase_r == PH_DATA;
  wire watchWr = wrEn && ptr_r >= `ADDR_WATCH_HOURS &&
                 ptr_r <= `ADDR_WATCH_SECONDS;

  // transfer phase, ack decision and byte pointer
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_r  <= PH_IDLE;
      ptr_r    <= 8'h00;
      ackReq_r <= 1'b0;
      sdaOut   <= 1'b0;
    end else if (startSeen) begin
      phase_r <= PH_SEL;
    end else if (stopSeen) begin
      phase_r <= PH_IDLE;
    end else if (rxValid) begin
      case (phase_r)
        PH_SEL: begin
          // only writes are served here; reads get no ack
          if (rxByte == {`DEV_SELECT_ADDR, 1'b0}) begin
            ackReq_r <= 1'b1;
            phase_r  <= PH_ADDR;
          end else begin
            ackReq_r <= 1'b0;
            phase_r  <= PH_SKIP;
          end
        end
        PH_ADDR: begin
          ackReq_r <= addrOk;
          ptr_r    <= rxByte;
          phase_r  <= addrOk ? PH_DATA : PH_SKIP;
        end
        PH_DATA: begin
          ackReq_r <= 1'b1;
          ptr_r    <= ptr_r + 8'h01;
        end
        PH_SKIP: ackReq_r <= 1'b0;
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  // alarm and impedance registers
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alarmHours_r   <= `RST_ALARM_HOURS;
      alarmMinutes_r <= `RST_ALARM_MINSEC;
      alarmSeconds_r <= `RST_ALARM_MINSEC;
      impConfig_r    <= `RST_IMPEDANCE;
    end else if (wrEn) begin
      case (ptr_r)
        `ADDR_ALARM_HOURS:   alarmHours_r   <= rxByte[4:0];
        `ADDR_ALARM_MINUTES: alarmMinutes_r <= rxByte[5:0];
        `ADDR_ALARM_SECONDS: alarmSeconds_r <= rxByte[5:0];
        `ADDR_IMPEDANCE:     impConfig_r    <= rxByte[2:0];
        default: impConfig_r <= impConfig_r;
      endcase
    end
  end

  // oscillator pin sync and one-second divider
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      oscSync   <= 3'h0;
      oscLvl    <= 1'b0;
      oscPrev   <= 1'b0;
      oscCnt_r  <= 16'h0000;
      secTick_r <= 1'b0;
    end else begin
      oscSync   <= {oscSync[1:0], oscIn};
      if (oscSync[1] == oscSync[2]) oscLvl <= oscSync[2];
      oscPrev   <= oscLvl;
      secTick_r <= 1'b0;
      if (oscLvl && !oscPrev) begin
        if (oscCnt_r == OSC_LAST) begin
          oscCnt_r  <= 16'h0000;
          secTick_r <= 1'b1;
        end else begin
          oscCnt_r <= oscCnt_r + 16'h0001;
        end
      end
    end
  end

  // watch: a bus write wins the cycle, a tick hit by it is held over
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      watchHours   <= `RST_WATCH_HOURS;
      watchMinutes <= `RST_WATCH_MINSEC;
      watchSeconds <= `RST_WATCH_MINSEC;
      tickPend_r   <= 1'b0;
      advanced_r   <= 1'b0;
    end else begin
      advanced_r <= 1'b0;
      if (watchWr) begin
        tickPend_r <= tickPend_r | secTick_r;
        case (ptr_r)
          `ADDR_WATCH_HOURS: watchHours <= (rxByte[4:0] > `HOURS_MAX) ?
                              `HOURS_MAX : rxByte[4:0];
          `ADDR_WATCH_MINUTES: watchMinutes <= rxByte[5:0];
          default: watchSeconds <= rxByte[5:0];
        endcase
      end else if (secTick_r || tickPend_r) begin
        tickPend_r <= 1'b0;
        advanced_r <= 1'b1;
        // >= so a written 60..63 also rolls over
        if (watchSeconds >= `MINSEC_MAX) begin
          watchSeconds <= 6'h00;
          if (watchMinutes >= `MINSEC_MAX) begin
            watchMinutes <= 6'h00;
            if (watchHours >= `HOURS_MAX) watchHours <= 5'h00;
            else watchHours <= watchHours + 5'h01;
          end else begin
            watchMinutes <= watchMinutes + 6'h01;
          end
        end else begin
          watchSeconds <= watchSeconds + 6'h01;
        end
      end
    end
  end

  // match only for a valid alarm time, once per advanced second
  wire alarmOk = alarmHours_r <= `HOURS_MAX &&
                 alarmMinutes_r <= `MINSEC_MAX &&
                 alarmSeconds_r <= `MINSEC_MAX;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alarmEvent <= 1'b0;
    end else begin
      alarmEvent <= advanced_r && alarmOk &&
                    alarmHours_r == watchHours &&
                    alarmMinutes_r == watchMinutes &&
                    alarmSeconds_r == watchSeconds;
    end
  end

  // delay select
  always @* begin
    case (impConfig_r[`IMP_DELAY_MSB:0])
      2'h0:    delayMs = DLY0;
      2'h1:    delayMs = DLY1;
      2'h2:    delayMs = DLY2;
      default: delayMs = DLY3;
    endcase
  end

  // impedance input sync, ms base and persistence counter
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      impSync           <= 3'h0;
      impLvl            <= 1'b0;
      msCnt_r           <= 17'h00000;
      msTick_r          <= 1'b0;
      impCnt_r          <= 10'h000;
      impedanceDetected <= 1'b0;
    end else begin
      impSync  <= {impSync[1:0], impedanceIn};
      if (impSync[1] == impSync[2]) impLvl <= impSync[2];
      msTick_r <= (msCnt_r == MS_LAST);
      msCnt_r  <= (msCnt_r == MS_LAST) ? 17'h00000 : msCnt_r + 17'h00001;
      if (!impConfig_r[`IMP_ENABLE_BIT] || !impLvl) begin
        impCnt_r          <= 10'h000;
        impedanceDetected <= 1'b0;
      end else if (msTick_r) begin
        // ms granularity: up to one ms early on the first count
        if (impCnt_r + 10'h001 >= delayMs) begin
          impedanceDetected <= 1'b1;
        end else begin
          impCnt_r <= impCnt_r + 10'h001;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- test/day_watch_alarm_properties.sv
`timescale 1ns/1ps
`default_nettype none

module day_watch_alarm_properties #(
  parameter CLK_KHZ = 125000
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       impedanceIn,
  input wire logic [4:0] watchHours,
  input wire logic [5:0] watchMinutes,
  input wire logic [5:0] watchSeconds,
  input wire logic       alarmEvent,
  input wire logic       impedanceDetected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // cycles the raw comparator has been high; 32 bits so it cannot wrap
  logic [31:0] highCnt_r;
  always @(posedge sys_clk or posedge reset) begin
    if (reset || !impedanceIn)
      highCnt_r <= 32'h0;
    else
      highCnt_r <= highCnt_r + 32'h1;
  end

  // ack stands for at least eight sys_clk cycles once raised
  sequence ackHeld;
    sdaOe [*8];
  endsequence
  // watch seconds moved one or two edges back
  sequence tickSeen;
    ($past(watchSeconds) != $past(watchSeconds, 2)) ||
    (watchSeconds != $past(watchSeconds));
  endsequence

  sda_low_only_a: assert property (sdaOut == 1'b0)
    else $error("data pin output value not low");
  ack_clk_low_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("ack raised while clock high");
  ack_held_a: assert property ($rose(sdaOe) |-> ackHeld)
    else $error("ack dropped early");
  hours_range_a: assert property (watchHours <= 5'h17)
    else $error("watch hours above 23");
  alarm_pulse_a: assert property (alarmEvent |=> !alarmEvent)
    else $error("alarm event longer than one cycle");
  alarm_tick_a: assert property (alarmEvent |-> tickSeen)
    else $error("alarm event without a watch tick");
  alarm_valid_a: assert property (alarmEvent |-> watchHours <= 5'h17 &&
    watchMinutes <= 6'h3b && watchSeconds <= 6'h3b)
    else $error("alarm event at an impossible time");
  imp_delay_a: assert property ($rose(impedanceDetected) |->
    highCnt_r >= 99 * CLK_KHZ)
    else $error("impedance flag before the shortest delay");
  imp_drop_a: assert property ((!impedanceIn) [*8] |->
    !impedanceDetected)
    else $error("impedance flag stays with input low");
endmodule

bind day_watch_alarm day_watch_alarm_properties #(.CLK_KHZ(CLK_KHZ)) props (
  .sys_clk(sys_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .impedanceIn(impedanceIn), .watchHours(watchHours),
  .watchMinutes(watchMinutes), .watchSeconds(watchSeconds),
  .alarmEvent(alarmEvent), .impedanceDetected(impedanceDetected));

`default_nettype wire

//--- test/serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
  input  wire logic sys_clk,
  input  wire logic sdaWire,
  output var  logic scl,
  output var  logic sdaDrv
);
  // released bus idles high through the pull-up
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // eight cycles a phase, well above the input filter's need
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic startCond();
    half();
    sdaDrv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stopCond();
    sdaDrv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaDrv = 1'b1;
    half();
  endtask

  // msb first; data moves only a phase after the clock falls
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
      half();
    end
    sdaDrv = 1'b1;
    half();
    scl = 1'b1;
    repeat (4) @(negedge sys_clk);
    ack = !sdaWire;
    repeat (4) @(negedge sys_clk);
    scl = 1'b0;
    half();
  endtask
endmodule

`default_nettype wire

//--- test/day_watch_alarm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "day_watch_defines.vh"

module day_watch_alarm_tb;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       oscIn = 1'b0;
  logic       oscEn = 1'b0;
  logic       impedanceIn = 1'b0;
  logic [4:0] ack;
  wire        scl, sdaDrv, sdaOut, sdaOe, alarmEvent, impedanceDetected;
  wire  [4:0] watchHours;
  wire  [5:0] watchMinutes, watchSeconds;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         alarmCnt = 0;
  // open drain: the master's drive or the device's enable pulls the wire low
  wire        sdaWire = sdaDrv & (sdaOut | ~sdaOe);

  always #4 sys_clk = ~sys_clk;
  // oscillator stands still unless a test lets the watch run
  always begin
    repeat (10) @(negedge sys_clk);
    if (oscEn) oscIn = ~oscIn;
  end
  always @(posedge sys_clk) if (alarmEvent === 1'b1) alarmCnt++;

  serial_master_model mst (.sys_clk(sys_clk), .sdaWire(sdaWire),
    .scl(scl), .sdaDrv(sdaDrv));
  day_watch_alarm #(.CLK_KHZ(10), .OSC_PER_SEC(4)) uut (
    .sys_clk(sys_clk), .reset(reset), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .oscIn(oscIn),
    .impedanceIn(impedanceIn), .watchHours(watchHours),
    .watchMinutes(watchMinutes), .watchSeconds(watchSeconds),
    .alarmEvent(alarmEvent), .impedanceDetected(impedanceDetected));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hms(input logic [23:0] t);
    chk({3'h0, watchHours}, t[23:16]);
    chk({2'h0, watchMinutes}, t[15:8]);
    chk({2'h0, watchSeconds}, t[7:0]);
  endtask

  // select, address, three data bytes; acks land in ack, select first
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic b;
    mst.startCond();
    mst.sendByte({`DEV_SELECT_ADDR, 1'b0}, b);
    ack[4] = b;
    mst.sendByte(a, b);
    ack[3] = b;
    for (int i = 0; i < 3; i++) begin
      mst.sendByte(d[23 - 8 * i -: 8], b);
      ack[2 - i] = b;
    end
    mst.stopCond();
  endtask

  task automatic runTo(input logic [5:0] s);
    int n;
    n = 0;
    oscEn = 1'b1;
    while (watchSeconds !== s && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    oscEn = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(8'(n < 400), 8'h01);
  endtask

  task automatic test_clamp();
    wr(`ADDR_WATCH_HOURS, 24'h194651);
    chk({3'h0, ack}, 8'h1f);
    hms(24'h170611);
    $display("test clamp done");
  endtask

  task automatic test_alarm();
    int base;
    wr(`ADDR_WATCH_HOURS, 24'h173b3b);
    wr(`ADDR_ALARM_HOURS, 24'h190001);
    base = alarmCnt;
    runTo(6'h00);
    hms(24'h000000);
    runTo(6'h01);
    chk(8'(alarmCnt - base), 8'h00);
    wr(`ADDR_ALARM_HOURS, 24'h004041);
    wr(`ADDR_WATCH_HOURS, 24'h000000);
    base = alarmCnt;
    runTo(6'h01);
    chk(8'(alarmCnt - base), 8'h01);
    $display("test alarm done");
  endtask

  task automatic test_range();
    int base;
    logic b;
    wr(8'h01, 24'h050505);
    chk({3'h0, ack}, 8'h10);
    wr(`ADDR_ALARM_HOURS, 24'h003c01);
    wr(`ADDR_WATCH_HOURS, 24'h003c00);
    base = alarmCnt;
    runTo(6'h01);
    chk(8'(alarmCnt - base), 8'h00);
    hms(24'h003c01);
    // read select: refused, so nothing later in the transfer may land
    mst.startCond();
    mst.sendByte({`DEV_SELECT_ADDR, 1'b1}, b);
    chk({7'h0, b}, 8'h00);
    mst.sendByte(`ADDR_WATCH_SECONDS, b);
    chk({7'h0, b}, 8'h00);
    mst.sendByte(8'h2a, b);
    mst.stopCond();
    hms(24'h003c01);
    $display("test range done");
  endtask

  task automatic test_imp();
    int ms[4] = '{100, 250, 500, 1000};
    wr(`ADDR_IMPEDANCE, 24'hf80000);
    impedanceIn = 1'b1;
    repeat (1200) @(negedge sys_clk);
    chk({7'h0, impedanceDetected}, 8'h00);
    impedanceIn = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_IMPEDANCE, {6'h01, 2'(c), 16'h0000});
      impedanceIn = 1'b1;
      repeat (ms[c] * 9) @(negedge sys_clk);
      chk({7'h0, impedanceDetected}, 8'h00);
      repeat (ms[c] + 30) @(negedge sys_clk);
      chk({7'h0, impedanceDetected}, 8'h01);
      impedanceIn = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk({7'h0, impedanceDetected}, 8'h00);
    end
    $display("test impedance done");
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    repeat (10) @(negedge sys_clk);
    hms(24'h000000);
    test_clamp();
    test_alarm();
    test_range();
    test_imp();
    end_sim();
  end

  // hang guard, about twice the expected run
  initial begin
    #640000;
    n_mismatch++;
    end_sim();
  end
endmodule

`default_nettype wire
